// ==== logic/adc_sequencer.sv ====
// Step sequencer of the auxiliary converter with its APB register file.
// Summary of operation
// - Bit 15 of a step configuration enables that step when set; steps start disabled.
// - Bits 14:13 pick the gain: 00 gives one, 01 gives two, 10 and 11 give four.
// - Bits 12:5 are reserved and always read back as zero.
// - Bit 4 picks the negative input: 0 is the analog ground reference, 1 is input seven.
// - Positive codes 0 to 7 pick external inputs zero to seven.
// - Positive codes 8 to 15 force the negative input and ignore bit 4.
// - Code 8 is the temperature sensor, 9 a short to ground, 12 the quarter I/O supply, 14 and 15 the rails over 103.
// - The second step register has index 0x92 and resets to 0x0002.
// - The first step register has index 0x91 and resets to 0x0001.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [DATA_W-1:0] pwdata_in,
  output logic      [DATA_W-1:0] prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              conv_done_in,
  output logic                   conv_start_out,
  output logic      [2:0]        conv_gain_out,
  output logic      [3:0]        pos_code_out,
  output logic      [2:0]        pos_src_out,
  output logic      [1:0]        neg_src_out,
  output logic                   ext_disconnect_out,
  output logic                   busy_out,
  output logic      [1:0]        step_number_out
);

  typedef enum logic [1:0] {st_idle, st_check, st_start, st_wait} seq_state_type;

  seq_state_type    state_q;
  seq_state_type    state_d;
  logic [CFG_W-1:0] cfg_q [NUM_STEPS];
  logic             cursor_q;
  logic             cursor_d;
  logic             run_q;
  logic             pass_done_q;
  logic             pready_q;
  logic             pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic             conv_start_q;
  logic [2:0]       conv_gain_q;
  logic [3:0]       pos_code_q;
  pos_src_type      pos_src_q;
  neg_src_type      neg_src_q;
  logic             ext_disconnect_q;
  logic             step1_written_q;
  logic             step2_written_q;

  step_decode_if dec_if ();

  step_decode u_decode (
    .dec (dec_if.decoder)
  );

  // Bus decode.
  wire setup_phase = psel_in & ~penable_in;
  wire access_done = psel_in & penable_in & pready_q;
  wire hit_step1   = (paddr_in == STEP1_ADDR);
  wire hit_step2   = (paddr_in == STEP2_ADDR);
  wire hit_ctrl    = (paddr_in == CTRL_ADDR);
  wire hit_status  = (paddr_in == STATUS_ADDR);
  wire hit_any     = hit_step1 | hit_step2 | hit_ctrl | hit_status;
  wire wr_done     = access_done & pwrite_in;
  wire wr_step1    = wr_done & hit_step1;
  wire wr_step2    = wr_done & hit_step2;
  wire wr_ctrl     = wr_done & hit_ctrl;
  wire wr_status   = wr_done & hit_status;

  wire [CFG_W-1:0] cfg_wdata = pwdata_in[CFG_W-1:0] & CFG_WRITE_MASK;

  wire [DATA_W-1:0] ctrl_word   = {{(DATA_W-1){1'b0}}, run_q};
  wire [DATA_W-1:0] status_word = {{(DATA_W-4){1'b0}}, pass_done_q,
                                   step_number_out, busy_out};
  wire [DATA_W-1:0] read_mux =
    hit_step1  ? {{(DATA_W-CFG_W){1'b0}}, cfg_q[0]} :
    hit_step2  ? {{(DATA_W-CFG_W){1'b0}}, cfg_q[1]} :
    hit_ctrl   ? ctrl_word :
    hit_status ? status_word : '0;

  // Sequencer decode.
  wire [CFG_W-1:0] sel_cfg   = cfg_q[cursor_q];
  wire             last_step = (cursor_q == 1'(NUM_STEPS - 1));
  wire             skip_last = (state_q == st_check) & ~dec_if.enable & last_step;
  wire             done_last = (state_q == st_wait) & conv_done_in & last_step;
  wire             pass_end  = skip_last | done_last;

  assign dec_if.cfg = sel_cfg;

  always_comb begin
    state_d  = state_q;
    cursor_d = cursor_q;
    unique case (state_q)
      st_idle: begin
        cursor_d = 1'b0;
        if (run_q) begin
          state_d = st_check;
        end
      end
      st_check: begin
        if (dec_if.enable) begin
          state_d = st_start;
        end else if (last_step) begin
          state_d = st_idle;
        end else begin
          cursor_d = 1'b1;
        end
      end
      st_start: begin
        state_d = st_wait;
      end
      st_wait: begin
        if (conv_done_in) begin
          if (last_step) begin
            state_d = st_idle;
          end else begin
            state_d  = st_check;
            cursor_d = 1'b1;
          end
        end
      end
    endcase
  end

  // Bus answer: zero wait states, error on an unmapped address.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase & ~hit_any;
      prdata_q  <= setup_phase ? read_mux : '0;
    end
  end

  // Step configuration registers.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q[0]        <= STEP1_RESET;
      cfg_q[1]        <= STEP2_RESET;
      step1_written_q <= 1'b0;
      step2_written_q <= 1'b0;
    end else begin
      if (wr_step1) begin
        cfg_q[0]        <= cfg_wdata;
        step1_written_q <= 1'b1;
      end
      if (wr_step2) begin
        cfg_q[1]        <= cfg_wdata;
        step2_written_q <= 1'b1;
      end
    end
  end

  // Run is set by software and cleared at the end of a pass; the software set wins.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_q       <= 1'b0;
      pass_done_q <= 1'b0;
    end else begin
      run_q       <= (wr_ctrl & pwdata_in[RUN_BIT]) | (run_q & ~pass_end);
      pass_done_q <= pass_end | (pass_done_q & ~(wr_status & pwdata_in[PASS_DONE_BIT]));
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q  <= st_idle;
      cursor_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cursor_q <= cursor_d;
    end
  end

  // The selection is captured when a step is entered, so a later write waits for the next visit.
  wire capture = (state_q == st_check) & dec_if.enable;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_gain_q      <= GAIN_X1;
      pos_code_q       <= '0;
      pos_src_q        <= src_external;
      neg_src_q        <= neg_ground;
      ext_disconnect_q <= 1'b0;
    end else if (capture) begin
      conv_gain_q      <= dec_if.gain;
      pos_code_q       <= dec_if.pos_code;
      pos_src_q        <= dec_if.pos_src;
      neg_src_q        <= dec_if.neg_src;
      ext_disconnect_q <= dec_if.ext_disconnect;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_start_q <= 1'b0;
      busy_out     <= 1'b0;
      step_number_out <= 2'h0;
    end else begin
      conv_start_q    <= (state_d == st_start);
      busy_out        <= (state_d != st_idle);
      step_number_out <= (state_d == st_idle) ? 2'h0 : {1'b0, cursor_d} + 2'h1;
    end
  end

  assign prdata_out         = prdata_q;
  assign pready_out         = pready_q;
  assign pslverr_out        = pslverr_q;
  assign conv_start_out     = conv_start_q;
  assign conv_gain_out      = conv_gain_q;
  assign pos_code_out       = pos_code_q;
  assign pos_src_out        = pos_src_q;
  assign neg_src_out        = neg_src_q;
  assign ext_disconnect_out = ext_disconnect_q;

  disabled_step_skip_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    (state_q == st_check) && !sel_cfg[ENABLE_BIT] |=>
      !conv_start_q && state_q == ($past(last_step) ? st_idle : st_check))
    else $error("Disabled step started a conversion.");

  gain_mapping_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    capture |=> conv_start_q && conv_gain_q == gain_of($past(sel_cfg[GAIN_HI:GAIN_LO])))
    else $error("Converter gain does not match the step gain field.");

  reserved_zero_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    setup_phase && (hit_step1 || hit_step2) |=> prdata_q[RSVD_HI:RSVD_LO] == 8'h00)
    else $error("Reserved step bits read back nonzero.");

  neg_manual_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    capture && sel_cfg[POS_HI:POS_LO] <= POS_LAST_EXTERNAL |=>
      neg_src_q == ($past(sel_cfg[NEG_BIT]) ? neg_ext_seven : neg_ground))
    else $error("Negative input does not follow its selection bit.");

  pos_external_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    capture && sel_cfg[POS_HI:POS_LO] <= POS_LAST_EXTERNAL |=>
      pos_src_q == src_external && pos_code_q == $past(sel_cfg[POS_HI:POS_LO]))
    else $error("External positive input not selected.");

  neg_automatic_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    capture && sel_cfg[POS_HI:POS_LO] > POS_LAST_EXTERNAL |=> neg_src_q == neg_automatic)
    else $error("Internal source did not force the negative input.");

  internal_source_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    capture |=> pos_src_q == src_of($past(sel_cfg[POS_HI:POS_LO])) &&
      ext_disconnect_q == ($past(sel_cfg[POS_HI:POS_LO]) == POS_SHORT))
    else $error("Internal source decode is wrong.");

  step2_reset_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    !step2_written_q |-> cfg_q[1] == STEP2_RESET)
    else $error("Second step register left its reset value unwritten.");

  step1_reset_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    setup_phase && hit_step1 && !step1_written_q && !wr_step1 |=>
      prdata_q == {{(DATA_W-CFG_W){1'b0}}, STEP1_RESET})
    else $error("First step register did not read its reset value.");

  ascending_order_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    (state_q == st_wait) && conv_done_in && !last_step |=>
      state_q == st_check && cursor_q && step_number_out == 2'h2)
    else $error("Sequencer did not advance to the next step.");

  enabled_step_start_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    (state_q == st_check) && sel_cfg[ENABLE_BIT] |=> conv_start_q && busy_out)
    else $error("Enabled step did not start a conversion.");

  reserved_write_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    wr_step2 |=> cfg_q[1][RSVD_HI:RSVD_LO] == 8'h00)
    else $error("Reserved bits of the second step register were stored.");

  step1_write_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    wr_step1 |=> cfg_q[0][POS_HI:POS_LO] == $past(pwdata_in[POS_HI:POS_LO]) &&
      cfg_q[0][ENABLE_BIT] == $past(pwdata_in[ENABLE_BIT]))
    else $error("First step register did not take the written fields.");

  first_step_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    (state_q == st_idle) && run_q |=>
      state_q == st_check && !cursor_q && step_number_out == 2'h1)
    else $error("Pass did not begin at the first step.");

  pass_end_a: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    pass_end |=> !busy_out && step_number_out == 2'h0 && pass_done_q)
    else $error("Pass end did not return the sequencer to idle.");

endmodule
`default_nettype wire

// ==== logic/step_decode.sv ====
// Decoder from one step configuration word to converter gain and input selection.
`timescale 1ns/1ps
`default_nettype none
module step_decode
  import adc_seq_pkg::*;
(
  step_decode_if.decoder dec
);
  wire       auto_neg;
  wire [3:0] pos_field;

  assign pos_field          = dec.cfg[POS_HI:POS_LO];
  assign auto_neg           = (pos_field > POS_LAST_EXTERNAL);
  assign dec.enable         = dec.cfg[ENABLE_BIT];
  assign dec.gain           = gain_of(dec.cfg[GAIN_HI:GAIN_LO]);
  assign dec.pos_code       = pos_field;
  assign dec.pos_src        = src_of(pos_field);
  assign dec.neg_src        = auto_neg ? neg_automatic :
                              (dec.cfg[NEG_BIT] ? neg_ext_seven : neg_ground);
  assign dec.ext_disconnect = (pos_field == POS_SHORT);
endmodule
`default_nettype wire

// ==== pkg/adc_seq_pkg.sv ====
// Constants, types and decode functions shared by the auxiliary converter step sequencer.
package adc_seq_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CFG_W  = 16;
  localparam int unsigned NUM_STEPS = 2;

  // Register indices; the byte address of a register is four times its index.
  localparam logic [7:0] STEP1_INDEX  = 8'h91;
  localparam logic [7:0] STEP2_INDEX  = 8'h92;
  localparam logic [7:0] CTRL_INDEX   = 8'h93;
  localparam logic [7:0] STATUS_INDEX = 8'h94;

  localparam logic [ADDR_W-1:0] STEP1_ADDR  = {STEP1_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] STEP2_ADDR  = {STEP2_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] CTRL_ADDR   = {CTRL_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};

  localparam logic [CFG_W-1:0] STEP1_RESET    = 16'h0001;
  localparam logic [CFG_W-1:0] STEP2_RESET    = 16'h0002;
  localparam logic [CFG_W-1:0] CFG_WRITE_MASK = 16'he01f;

  // Step configuration field positions.
  localparam int unsigned ENABLE_BIT = 15;
  localparam int unsigned GAIN_HI    = 14;
  localparam int unsigned GAIN_LO    = 13;
  localparam int unsigned RSVD_HI    = 12;
  localparam int unsigned RSVD_LO    = 5;
  localparam int unsigned NEG_BIT    = 4;
  localparam int unsigned POS_HI     = 3;
  localparam int unsigned POS_LO     = 0;

  // Control and status field positions.
  localparam int unsigned RUN_BIT     = 0;
  localparam int unsigned BUSY_BIT    = 0;
  localparam int unsigned CURSOR_LO   = 1;
  localparam int unsigned PASS_DONE_BIT = 3;

  localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
  localparam logic [2:0] GAIN_X1 = 3'h1;
  localparam logic [2:0] GAIN_X2 = 3'h2;
  localparam logic [2:0] GAIN_X4 = 3'h4;

  localparam logic [3:0] POS_LAST_EXTERNAL = 4'h7;
  localparam logic [3:0] POS_TEMPERATURE   = 4'h8;
  localparam logic [3:0] POS_SHORT         = 4'h9;
  localparam logic [3:0] POS_IO_QUARTER    = 4'hc;
  localparam logic [3:0] POS_ANALOG_RAIL   = 4'he;
  localparam logic [3:0] POS_DIGITAL_RAIL  = 4'hf;

  typedef enum logic [2:0] {
    src_external,
    src_temperature,
    src_short,
    src_io_quarter,
    src_analog_rail,
    src_digital_rail,
    src_internal_other
  } pos_src_type;

  typedef enum logic [1:0] {
    neg_ground,
    neg_ext_seven,
    neg_automatic
  } neg_src_type;

  function automatic logic [2:0] gain_of(input logic [1:0] code);
    gain_of = (code == GAIN_CODE_X1) ? GAIN_X1 : (code == GAIN_CODE_X2) ? GAIN_X2 : GAIN_X4;
  endfunction

  function automatic pos_src_type src_of(input logic [3:0] code);
    src_of = (code <= POS_LAST_EXTERNAL) ? src_external :
             (code == POS_TEMPERATURE)   ? src_temperature :
             (code == POS_SHORT)         ? src_short :
             (code == POS_IO_QUARTER)    ? src_io_quarter :
             (code == POS_ANALOG_RAIL)   ? src_analog_rail :
             (code == POS_DIGITAL_RAIL)  ? src_digital_rail : src_internal_other;
  endfunction

endpackage

// ==== pkg/step_decode_if.sv ====
// Carrier between the sequencer and its step configuration decoder.
`timescale 1ns/1ps
`default_nettype none
interface step_decode_if;
  import adc_seq_pkg::*;
  logic [CFG_W-1:0] cfg;
  logic             enable;
  logic [2:0]       gain;
  logic [3:0]       pos_code;
  pos_src_type      pos_src;
  neg_src_type      neg_src;
  logic             ext_disconnect;
  modport decoder (input cfg, output enable, gain, pos_code, pos_src, neg_src, ext_disconnect);
  modport user    (output cfg, input enable, gain, pos_code, pos_src, neg_src, ext_disconnect);
endinterface
`default_nettype wire

// ==== tb/adc_sequencer_step_config_tb.sv ====
// Self-checking testbench for the auxiliary converter step sequencer.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_step_config_tb;
  import adc_seq_pkg::*;

  logic              clk;
  logic              arst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata_out;
  logic              pready_out;
  logic              pslverr_out;
  logic              conv_done;
  logic              conv_start_out;
  logic [2:0]        conv_gain_out;
  logic [3:0]        pos_code_out;
  logic [2:0]        pos_src_out;
  logic [1:0]        neg_src_out;
  logic              ext_disconnect_out;
  logic              busy_out;
  logic [1:0]        step_number_out;
  int                n_mismatch;
  int                compares;
  logic [31:0]       rng;
  logic [15:0]       cfg [2];

  adc_sequencer adc_sequencer_inst (
    .ref_clk_in         (clk),
    .arst_n_in          (arst_n),
    .psel_in            (psel),
    .penable_in         (penable),
    .pwrite_in          (pwrite),
    .paddr_in           (paddr),
    .pwdata_in          (pwdata),
    .prdata_out         (prdata_out),
    .pready_out         (pready_out),
    .pslverr_out        (pslverr_out),
    .conv_done_in       (conv_done),
    .conv_start_out     (conv_start_out),
    .conv_gain_out      (conv_gain_out),
    .pos_code_out       (pos_code_out),
    .pos_src_out        (pos_src_out),
    .neg_src_out        (neg_src_out),
    .ext_disconnect_out (ext_disconnect_out),
    .busy_out           (busy_out),
    .step_number_out    (step_number_out)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the rising edge that sees pready high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    rd = prdata_out;
    err = pslverr_out;
    if (n >= 50) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [2:0] exp_gain(input logic [1:0] g);
    exp_gain = (g == 2'h0) ? 3'h1 : (g == 2'h1) ? 3'h2 : 3'h4;
  endfunction

  function automatic logic [2:0] exp_src(input logic [3:0] p);
    case (p)
      4'h8: exp_src = 3'h1;
      4'h9: exp_src = 3'h2;
      4'hc: exp_src = 3'h3;
      4'he: exp_src = 3'h4;
      4'hf: exp_src = 3'h5;
      default: exp_src = (p <= 4'h7) ? 3'h0 : 3'h6;
    endcase
  endfunction

  // Programs both steps, runs one pass and compares each visited step with the model.
  task automatic run_pass(input logic [31:0] w1, input logic [31:0] w2);
    logic [31:0] rd;
    logic        err;
    int          q[$];
    int          s;
    int          guard;
    int          seen_busy;
    int          waits;
    logic [15:0] c;
    apb(1'b1, STEP1_ADDR, w1, rd, err);
    apb(1'b1, STEP2_ADDR, w2, rd, err);
    cfg[0] = w1[15:0] & 16'he01f;
    cfg[1] = w2[15:0] & 16'he01f;
    apb(1'b0, STEP1_ADDR, 32'h0, rd, err);
    check(rd, {16'h0, cfg[0]});
    apb(1'b0, STEP2_ADDR, 32'h0, rd, err);
    check(rd, {16'h0, cfg[1]});
    for (int i = 0; i < 2; i++) begin
      if (cfg[i][15]) q.push_back(i + 1);
    end
    apb(1'b1, CTRL_ADDR, 32'h1, rd, err);
    seen_busy = 0;
    for (guard = 0; guard < 300; guard++) begin
      @(negedge clk);
      if (busy_out === 1'b1) seen_busy = 1;
      if (conv_start_out === 1'b1) begin
        s = (q.size() > 0) ? q.pop_front() : 0;
        check(32'(step_number_out), 32'(s));
        c = (s > 0) ? cfg[s - 1] : 16'h0;
        check(32'(conv_gain_out), 32'(exp_gain(c[14:13])));
        check(32'(pos_code_out), 32'(c[3:0]));
        check(32'(pos_src_out), 32'(exp_src(c[3:0])));
        check(32'(neg_src_out), c[3] ? 32'h2 : 32'(c[4]));
        check(32'(ext_disconnect_out), 32'(c[3:0] == 4'h9));
        waits = int'(rng[1:0]);
        rng = xorshift(rng);
        repeat (waits) @(posedge clk);
        @(posedge clk);
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
      end else if (seen_busy == 1 && busy_out === 1'b0) begin
        break;
      end
    end
    check(32'(q.size()), 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0, rd, err);
    check(rd, 32'h8);
    apb(1'b1, STATUS_ADDR, 32'h8, rd, err);
    apb(1'b0, STATUS_ADDR, 32'h0, rd, err);
    check(rd, 32'h0);
    apb(1'b0, CTRL_ADDR, 32'h0, rd, err);
    check(rd, 32'h0);
  endtask

  initial begin
    logic [31:0] rd;
    logic        err;
    logic [31:0] w1;
    logic [31:0] w2;
    n_mismatch = 0;
    compares = 0;
    rng = 32'd67794;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    conv_done = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check(32'(conv_gain_out), 32'h1);
    check(32'(busy_out), 32'h0);
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, STEP1_ADDR, 32'h0, rd, err);
    check(rd, 32'h1);
    apb(1'b0, STEP2_ADDR, 32'h0, rd, err);
    check(rd, 32'h2);
    apb(1'b0, 10'h000, 32'h0, rd, err);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, 10'h3fc, 32'hffffffff, rd, err);
    check(32'(err), 32'h1);
    // Every positive code and gain code, with enables varied and junk in reserved bits.
    for (int i = 0; i < 16; i++) begin
      w1 = xorshift(rng);
      w2 = xorshift(w1);
      rng = w2;
      w1[15] = (i % 4 != 3);
      w1[14:13] = 2'(i % 4);
      w1[3:0] = 4'(i);
      w2[15] = (i % 3 != 0);
      w2[14:13] = 2'((i + 1) % 4);
      w2[3:0] = 4'(15 - i);
      run_pass(w1, w2);
    end
    // A reset after the last pass, with the sequencer idle, must bring both step registers back to their defaults.
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, STEP1_ADDR, 32'h0, rd, err);
    check(rd, 32'h1);
    apb(1'b0, STEP2_ADDR, 32'h0, rd, err);
    check(rd, 32'h2);
    end_of_test();
  end

  initial begin
    #200_000;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
